// ---- dce_pkg.sv ----
package dce_pkg;

  // instruction word layout
  localparam int INSTR_W        = 16;
  localparam int MASK_LSB       = 0;   // four-bit mask field
  localparam int STATE_LSB      = 4;   // four-bit expected-state field
  localparam int FLAG_W         = 4;
  localparam int SRC_LSB        = 8;   // two-bit source selector
  localparam int COUNT_BIT      = 12;  // one or two instructions
  localparam int SUM_W          = 32;

  // flag positions inside the four-bit fields
  localparam int FLAG_CARRY     = 0;
  localparam int FLAG_OVERFLOW  = 1;
  localparam int FLAG_NEGATIVE  = 2;
  localparam int FLAG_ZERO      = 3;

  // condition source codes
  localparam logic [1:0] SRC_PIN_LOW = 2'h0;
  localparam logic [1:0] SRC_TC_SET  = 2'h1;
  localparam logic [1:0] SRC_TC_CLR  = 2'h2;
  localparam logic [1:0] SRC_NONE    = 2'h3;

  // reset values
  localparam logic       RST_COND    = 1'b0;
  localparam logic [1:0] RST_SKIP    = 2'h0;
  localparam logic       RST_VALID   = 1'b0;

  // instruction counts for conditional execute
  localparam logic [1:0] COUNT_ONE   = 2'h1;
  localparam logic [1:0] COUNT_TWO   = 2'h2;

  typedef struct packed {
    logic zero;
    logic negative;
    logic overflow;
    logic carry;
  } dce_flags_t;

  typedef struct packed {
    logic       valid;
    logic       cond_exec;
    logic [INSTR_W-1:0] word;
  } dce_instr_t;

endpackage : dce_pkg

// ---- dce_flag_eval.sv ----
`timescale 1ns/1ps
// combinational flag condition evaluation
module dce_flag_eval (
  // inputs
  input  wire logic [dce_pkg::SUM_W-1:0] sum_in,
  input  wire logic                      overflow_in,
  input  wire logic                      carry_in,
  // result
  output      dce_pkg::dce_flags_t       flags_out
);

  // evaluate the four conditions of the main sum register
  always_comb begin
    flags_out.zero     = (sum_in == '0);                       // RQ2
    flags_out.negative = sum_in[dce_pkg::SUM_W-1];             // RQ2
    flags_out.overflow = overflow_in;                          // RQ2
    flags_out.carry    = carry_in;                             // RQ2
  end

endmodule : dce_flag_eval

// ---- dce_cond_eval.sv ----
`timescale 1ns/1ps
// How it works
// (RQ1) Selector 00 tests pin low, 01 flag set, 10 flag clear, 11 none.
// (RQ2) Four flags: sum zero, sum negative, overflow, carry.
// (RQ3) Low four instruction bits form the flag mask.
// (RQ4) Mask one selects a flag; unmasked flags never matter.
// (RQ5) Bits four to seven give each selected flag's expected state.
// (RQ6) Mask ANDed with matched flags; any set bit means condition met.
// (RQ7) Conditional execute runs one or two next instructions on count field.
// (RQ8) One registered condition-true output feeds the program sequencer.
module dce_cond_eval (
  // clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_n_in,
  // instruction from instruction register
  input  wire dce_pkg::dce_instr_t       instr_in,
  // processor state
  input  wire logic [dce_pkg::SUM_W-1:0] main_sum_register_in,
  input  wire logic                      overflow_in,
  input  wire logic                      carry_in,
  input  wire logic                      test_control_flag_in,
  input  wire logic                      branch_input_pin_in,
  // to program sequencer
  output      logic                      cond_valid_out,
  output      logic                      cond_true_out,
  output      logic [1:0]                exec_count_out
);

  // flag conditions of the main sum register
  dce_pkg::dce_flags_t        flags;
  logic [dce_pkg::FLAG_W-1:0] flag_vec;

  // fields of the instruction word
  logic [dce_pkg::FLAG_W-1:0] mask;
  logic [dce_pkg::FLAG_W-1:0] expect_st;
  logic [1:0]                 condition_source_select;
  logic                       count_two;
  logic                       mask_empty;

  // one select line per source code
  logic                       sel_pin_low;
  logic                       sel_tc_set;
  logic                       test_control_clear_cond;
  logic                       sel_none;

  // the three source conditions before selection
  logic                       pin_low_cond;
  logic                       tc_set_cond;
  logic                       tc_clr_cond;

  // per-flag and combined results
  logic [dce_pkg::FLAG_W-1:0] match;
  logic                       src_ok;
  logic                       flag_ok;
  logic                       cond_d;

  // count of instructions to run conditionally
  logic [1:0]                 count_d;

  // next values of the result registers
  logic                       cond_valid_d;
  logic                       cond_true_d;
  logic [1:0]                 exec_count_d;

  // result registers, one per output
  logic                       cond_valid_q;
  logic                       cond_true_q;
  logic [1:0]                 exec_count_q;

  // zero and negative from the sum, overflow and carry passed through
  // flags must already reflect the instruction ahead of this one
  dce_flag_eval i_dce_flag_eval (
    .sum_in      (main_sum_register_in),
    .overflow_in (overflow_in),
    .carry_in    (carry_in),
    .flags_out   (flags)                                   // RQ2
  );

  // place each flag at its bit of the mask and state fields
  always_comb begin
    flag_vec                         = '0;
    flag_vec[dce_pkg::FLAG_ZERO]     = flags.zero;          // RQ2
    flag_vec[dce_pkg::FLAG_NEGATIVE] = flags.negative;      // RQ2
    flag_vec[dce_pkg::FLAG_OVERFLOW] = flags.overflow;      // RQ2
    flag_vec[dce_pkg::FLAG_CARRY]    = flags.carry;         // RQ2
  end

  // low nibble is the mask of flags under test
  assign mask =
    instr_in.word[dce_pkg::MASK_LSB +: dce_pkg::FLAG_W];    // RQ3

  // next nibble is the expected state of each tested flag
  assign expect_st =
    instr_in.word[dce_pkg::STATE_LSB +: dce_pkg::FLAG_W];   // RQ5

  // two-bit source selector
  assign condition_source_select =
    instr_in.word[dce_pkg::SRC_LSB +: 2];                   // RQ1

  // count bit: cleared for one instruction, set for two
  assign count_two = instr_in.word[dce_pkg::COUNT_BIT];     // RQ7

  // an all-zero mask tests no flag at all
  assign mask_empty = (mask == '0);                         // RQ4

  // one-hot decode of the source selector
  always_comb begin
    sel_pin_low             = 1'b0;
    sel_tc_set              = 1'b0;
    test_control_clear_cond = 1'b0;
    sel_none                = 1'b0;
    case (condition_source_select)
      dce_pkg::SRC_PIN_LOW: sel_pin_low             = 1'b1; // RQ1
      dce_pkg::SRC_TC_SET:  sel_tc_set              = 1'b1; // RQ1
      dce_pkg::SRC_TC_CLR:  test_control_clear_cond = 1'b1; // RQ1
      default:              sel_none                = 1'b1; // RQ1
    endcase
  end

  // raw source conditions; the branch pin counts when low
  assign pin_low_cond = ~branch_input_pin_in;               // RQ1
  assign tc_set_cond  = test_control_flag_in;               // RQ1
  assign tc_clr_cond  = ~test_control_flag_in;              // RQ1

  // selected source condition, false for the no-condition code
  always_comb begin
    if (sel_pin_low) begin
      src_ok = pin_low_cond;                                // RQ1
    end else if (sel_tc_set) begin
      src_ok = tc_set_cond;                                 // RQ1
    end else if (test_control_clear_cond) begin
      src_ok = tc_clr_cond;                                 // RQ1
    end else begin
      src_ok = 1'b0;                                        // RQ1
    end
  end

  // per-flag test: masked flag agrees with its expected state
  genvar gi;
  generate
    for (gi = 0; gi < dce_pkg::FLAG_W; gi++) begin : g_match
      logic tested;
      logic agrees;
      // a cleared mask bit keeps this flag out of the result
      assign tested    = mask[gi];                          // RQ4
      // set state bit wants the flag true, cleared wants it false
      assign agrees    = (flag_vec[gi] == expect_st[gi]);   // RQ5
      assign match[gi] = tested & agrees;                   // RQ4
    end
  endgenerate

  // any surviving bit of the masked result meets the condition
  assign flag_ok = |match;                                  // RQ6

  // selector 11 leaves flags only, an empty mask leaves source only
  always_comb begin
    if (sel_none) begin
      cond_d = flag_ok;                                     // RQ6
    end else if (mask_empty) begin
      cond_d = src_ok;                                      // RQ1
    end else begin
      cond_d = src_ok | flag_ok;                            // RQ1 RQ6
    end
  end

  // conditional execute runs one or two instructions when met
  always_comb begin
    if (instr_in.cond_exec && cond_d) begin
      if (count_two) begin
        count_d = dce_pkg::COUNT_TWO;                       // RQ7
      end else begin
        count_d = dce_pkg::COUNT_ONE;                       // RQ7
      end
    end else begin
      count_d = dce_pkg::RST_SKIP;
    end
  end

  // a cycle without an instruction reports nothing
  always_comb begin
    cond_valid_d = instr_in.valid;
    cond_true_d  = instr_in.valid & cond_d;                 // RQ8
    if (instr_in.valid) begin
      exec_count_d = count_d;                               // RQ7
    end else begin
      exec_count_d = dce_pkg::RST_SKIP;
    end
  end

  // valid echo register
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cond_valid_q <= dce_pkg::RST_VALID;
    end else begin
      cond_valid_q <= cond_valid_d;
    end
  end

  // condition-true register
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cond_true_q <= dce_pkg::RST_COND;
    end else begin
      cond_true_q <= cond_true_d;                           // RQ8
    end
  end

  // instruction count register
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      exec_count_q <= dce_pkg::RST_SKIP;
    end else begin
      exec_count_q <= exec_count_d;                         // RQ7
    end
  end

  // outputs straight from the result registers, glitch free
  assign cond_valid_out = cond_valid_q;
  assign cond_true_out  = cond_true_q;                      // RQ8
  assign exec_count_out = exec_count_q;                     // RQ7

endmodule : dce_cond_eval

// ---- dce_cond_eval_assertions.sv ----
`timescale 1ns/1ps
module dce_cond_eval_chk (
  // clock, reset, inputs and outputs
  input wire logic ref_clk_in, rst_n_in, overflow_in, carry_in,
  input wire dce_pkg::dce_instr_t instr_in,
  input wire logic [dce_pkg::SUM_W-1:0] main_sum_register_in,
  input wire logic test_control_flag_in, branch_input_pin_in,
  input wire logic cond_valid_out, cond_true_out,
  input wire logic [1:0] exec_count_out
);
  logic [15:0] w;
  logic [3:0]  f, m;
  logic        v, p, e;
  // reference evaluation of the condition
  assign w = instr_in.word;
  assign v = instr_in.valid;
  assign f = {main_sum_register_in == '0, main_sum_register_in[31],
              overflow_in, carry_in};
  assign m = w[3:0] & ~(f ^ w[7:4]);
  assign p = w[9:8] == 2'h0 ? !branch_input_pin_in :
             w[9:8] == 2'h1 ? test_control_flag_in :
             w[9:8] == 2'h2 ? !test_control_flag_in : 1'b0;
  assign e = p | (|m);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_valid_echo: assert property (v |=> cond_valid_out)
    else $error("valid not echoed");
  a_refused_quiet: assert property (!v |=> !cond_true_out &&
    exec_count_out == 2'h0) else $error("output without request");
  a_cond_result: assert property (v |=> cond_true_out == $past(e))
    else $error("condition result wrong");
  a_source_sel: assert property (v && w[3:0] == 4'h0 |=>
    cond_true_out == $past(p)) else $error("selector result wrong");
  a_flag_state: assert property (v && w[9:8] == 2'h3 |=>
    cond_true_out == $past(|m)) else $error("flag match wrong");
  a_mask_none: assert property (v && w[9:0] == 10'h3f0 |=>
    !cond_true_out) else $error("unmasked flag counted");
  a_count_two: assert property (v && instr_in.cond_exec && e && w[12]
    |=> exec_count_out == 2'h2) else $error("count two wrong");
  a_count_one: assert property (v && instr_in.cond_exec && e && !w[12]
    |=> exec_count_out == 2'h1) else $error("count one wrong");
endmodule : dce_cond_eval_chk
bind dce_cond_eval dce_cond_eval_chk i_dce_cond_eval_chk (.*);

// ---- tb_dce_cond_eval.sv ----
`timescale 1ns/1ps
module tb_dce_cond_eval;
  logic clk = 0, rst_n = 0, ov = 0, cy = 0, tc = 0, pin = 1, cv, ct;
  logic [31:0] sum = 0;
  logic [1:0]  ec;
  dce_pkg::dce_instr_t ins = '0;
  int n_fail = 0, compares = 0, cyc = 0;
  dce_cond_eval i_dce_cond_eval (.ref_clk_in(clk), .rst_n_in(rst_n),
    .instr_in(ins), .main_sum_register_in(sum), .overflow_in(ov),
    .carry_in(cy), .test_control_flag_in(tc), .branch_input_pin_in(pin),
    .cond_valid_out(cv), .cond_true_out(ct), .exec_count_out(ec));
  initial forever #12.5 clk = ~clk;
  // cycle ceiling
  always @(posedge clk) if (++cyc > 200) begin n_fail++; results(); end
  task results();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // one request, judged one cycle later
  task chk(input logic [15:0] w, input logic x, e);
    logic [1:0] n;
    n = (x && e) ? (w[12] ? 2'h2 : 2'h1) : 2'h0;
    ins = '{1'b1, x, w};
    @(negedge clk);
    compares++;
    if (cv !== 1'b1 || ct !== e || ec !== n) begin
      n_fail++;
      $display("BAD word %h exp 1/%b/%h got %b/%b/%h", w, e, n, cv, ct, ec);
    end
  endtask : chk
  task t_src();
    pin = 0; chk(16'h0000, 0, 1); pin = 1; chk(16'h0000, 0, 0);
    tc = 1; chk(16'h0100, 0, 1); chk(16'h0200, 0, 0);
    tc = 0; chk(16'h0200, 0, 1); chk(16'h0300, 0, 0);
  endtask : t_src
  task t_flags();
    chk(16'h0388, 0, 1); chk(16'h0308, 0, 0); chk(16'h03f0, 0, 0);
    sum = 32'h8000_0000; chk(16'h0344, 0, 1); chk(16'h03cc, 0, 1);
    ov = 1; chk(16'h0322, 0, 1); chk(16'h0311, 0, 0);
    cy = 1; chk(16'h0311, 0, 1); sum = 5; chk(16'h030c, 0, 1);
  endtask : t_flags
  task t_exec();
    pin = 0; chk(16'h1000, 1, 1); chk(16'h0000, 1, 1);
    pin = 1; chk(16'h1000, 1, 0);
  endtask : t_exec
  // mid-run reset: outputs cleared, first edge after release answers
  task t_reset();
    pin = 0; rst_n = 0; ins = '{1'b1, 1'b1, 16'h1000};
    @(negedge clk);
    compares++;
    if (cv !== 1'b0 || ct !== 1'b0 || ec !== 2'h0) begin
      n_fail++;
      $display("BAD reset exp 0/0/0 got %b/%b/%h", cv, ct, ec);
    end
    rst_n = 1; chk(16'h1000, 1, 1);
  endtask : t_reset
  task t_idle();
    pin = 0; ins = '{1'b0, 1'b1, 16'h1000};
    @(negedge clk);
    compares++;
    if (cv !== 1'b0 || ct !== 1'b0 || ec !== 2'h0) begin
      n_fail++;
      $display("BAD idle exp 0/0 got %b/%h", ct, ec);
    end
  endtask : t_idle
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_src(); t_flags(); t_reset(); t_exec(); t_idle();
    results();
  end
endmodule : tb_dce_cond_eval
